// ---- src/fpcl_pkg.sv ----
// What this block does
// - 8-bit ratio: 1 plain, 2 compressed
// - 16-bit ratio: 1, 2 encrypted, 4 compressed
// - Host holds each value for ratio clocks
// - Host adds no trailing clocks after the last word
// - Host pulls request low at least 2 us
// - Device lowers complete and status within 600 ns
// - Status low between 268 and 1506 us
// - Status released within 1506 us of request
// - First load clock 2 us after status
// - Device captures data on rising load clock
// - Load clock at most 125 MHz, 45% phases
// - Internal init: user mode 175-437 us later
// - User init clock enabled after four periods
// - Initialization takes 8576 init clock cycles
// - Power-on delay selectable: fast or standard
package fpcl_pkg;

  localparam int DATA_W = 16;
  localparam int CNT_W = 23;
  localparam int RATIO_W = 3;

  // Strap positions in scheme_select_pins
  localparam int SCHEME_W = 5;
  localparam int SEL_BUS16 = 0;
  localparam int SEL_ENCRYPT = 1;
  localparam int SEL_COMPRESS = 2;
  localparam int SEL_POR_FAST = 3;
  localparam int SEL_USER_INIT = 4;

  localparam int CLK_PERIOD_NS = 25;
  localparam int IMAGE_WORDS_DEF = 64;
  localparam int HOST_DIV_DEF = 2;
  localparam int FIFO_DEPTH_DEF = 32;

  localparam int REQ_LOW_MIN_NS = 2000;
  localparam int REQ_LOW_CYC = (REQ_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REQ_RESPONSE_MAX_NS = 600;
  localparam int STATUS_LOW_MIN_US = 268;
  localparam int STATUS_LOW_MAX_US = 1506;
  localparam int STATUS_LOW_CYC =
    (STATUS_LOW_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ST2CK_MIN_US = 2;
  localparam int ST2CK_CYC = (ST2CK_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOAD_CLK_MAX_MHZ = 125;
  localparam int LOAD_CLK_MIN_PERIOD_NS = 1000 / LOAD_CLK_MAX_MHZ;
  localparam int CD2CU_NS = 4 * LOAD_CLK_MIN_PERIOD_NS;
  localparam int CD2CU_CYC = (CD2CU_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_CYCLES = 8576;
  localparam int POR_FAST_MIN_MS = 4;
  localparam int POR_FAST_MAX_MS = 12;
  localparam int POR_STD_MIN_MS = 100;
  localparam int POR_STD_MAX_MS = 300;
  localparam int POR_FAST_CYC = POR_FAST_MIN_MS * 1000000 / CLK_PERIOD_NS;
  localparam int POR_STD_CYC = POR_STD_MIN_MS * 1000000 / CLK_PERIOD_NS;

  typedef enum {DEV_POR, DEV_STAT_LOW, DEV_LOAD, DEV_INIT_WAIT, DEV_INIT, DEV_USER}
    fpcl_dev_state_t;
  typedef enum {HST_IDLE, HST_REQ, HST_WAIT_REL, HST_GAP, HST_STREAM, HST_WAIT_DONE,
    HST_DONE} fpcl_host_state_t;

  function automatic logic [RATIO_W-1:0] fpcl_ratio(input logic bus16, input logic enc,
                                                    input logic comp);
    logic [RATIO_W-1:0] r;
    r = 3'h1;
    if (!bus16) begin
      r = comp ? 3'h2 : 3'h1;
    end else if (comp) begin
      r = 3'h4;
    end else if (enc) begin
      r = 3'h2;
    end
    return r;
  endfunction

endpackage

// ---- src/fpcl_link_if.sv ----
`timescale 1ns/1ps
interface fpcl_link_if;
  logic config_request_n;
  logic load_clock;
  logic [fpcl_pkg::DATA_W-1:0] load_data;
  logic status_out;
  logic status_oe;
  logic config_status_n;
  logic load_complete;

  // Open-drain status wire, pulled up when nobody drives it
  assign config_status_n = !(status_oe && !status_out);

  modport dev (
    input config_request_n,
    input load_clock,
    input load_data,
    input config_status_n,
    output status_out,
    output status_oe,
    output load_complete
  );

  modport host (
    output config_request_n,
    output load_clock,
    output load_data,
    input config_status_n,
    input load_complete
  );
endinterface

// ---- src/fpcl_device.sv ----
`timescale 1ns/1ps
module fpcl_device #(
  parameter int IMAGE_WORDS = fpcl_pkg::IMAGE_WORDS_DEF,
  parameter int STATUS_LOW_CYCLES = fpcl_pkg::STATUS_LOW_CYC,
  parameter int INIT_COUNT = fpcl_pkg::INIT_CYCLES,
  parameter int POR_FAST_CYCLES = fpcl_pkg::POR_FAST_CYC,
  parameter int POR_STD_CYCLES = fpcl_pkg::POR_STD_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  fpcl_link_if.dev link,
  input wire logic [fpcl_pkg::SCHEME_W-1:0] scheme_select_pins,
  input wire logic user_init_clock,
  output logic user_clock_enable,
  output logic user_mode,
  output logic image_loaded,
  output logic [fpcl_pkg::DATA_W-1:0] image_check
);
  import fpcl_pkg::*;

  localparam int WORD_W = $clog2(IMAGE_WORDS + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic req_m_r, req_s_r;
  logic uck_m_r, uck_s_r, uck_d_r;
  logic [SCHEME_W-1:0] sel_m_r, sel_s_r;
  logic done_m_r, done_s_r;
  logic link_done_r;
  logic uck_rise;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_m_r <= 1'b1;
      req_s_r <= 1'b1;
      sel_m_r <= '0;
      sel_s_r <= '0;
    end else begin
      req_m_r <= link.config_request_n;
      req_s_r <= req_m_r;
      sel_m_r <= scheme_select_pins;
      sel_s_r <= sel_m_r;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      uck_m_r <= 1'b0;
      uck_s_r <= 1'b0;
      uck_d_r <= 1'b0;
      done_m_r <= 1'b0;
      done_s_r <= 1'b0;
    end else begin
      uck_m_r <= user_init_clock;
      uck_s_r <= uck_m_r;
      uck_d_r <= uck_s_r;
      done_m_r <= link_done_r;
      done_s_r <= done_m_r;
    end
  end

  // User clock is sampled, so it must run well below clk/2
  assign uck_rise = uck_s_r && !uck_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer on the internal clock

  fpcl_dev_state_t state_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] por_last;
  logic [RATIO_W-1:0] ratio_r;
  logic user_opt_r;
  logic bus16_r;
  logic link_clr_r;
  logic status_low_r;
  logic complete_r;
  logic init_tick;

  assign por_last = sel_s_r[SEL_POR_FAST] ? CNT_W'(POR_FAST_CYCLES - 1) :
                    CNT_W'(POR_STD_CYCLES - 1);
  assign init_tick = user_opt_r ? uck_rise : 1'b1;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= DEV_POR;
      cnt_r <= '0;
      ratio_r <= 3'h1;
      user_opt_r <= 1'b0;
      bus16_r <= 1'b0;
      link_clr_r <= 1'b1;
      status_low_r <= 1'b1;
      complete_r <= 1'b0;
      user_clock_enable <= 1'b0;
      user_mode <= 1'b0;
    end else if (state_r != DEV_POR && !req_s_r) begin
      // Request low restarts from any later state
      state_r <= DEV_STAT_LOW;
      cnt_r <= '0;
      link_clr_r <= 1'b1;
      status_low_r <= 1'b1;
      complete_r <= 1'b0;
      user_clock_enable <= 1'b0;
      user_mode <= 1'b0;
    end else begin
      case (state_r)
        DEV_POR: begin
          if (cnt_r == por_last) begin
            state_r <= DEV_STAT_LOW;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        DEV_STAT_LOW: begin
          if (cnt_r != CNT_W'(STATUS_LOW_CYCLES - 1)) begin
            cnt_r <= cnt_r + 1'b1;
          end else if (req_s_r) begin
            // Straps frozen here; link logic reads them only after release
            ratio_r <= fpcl_ratio(sel_s_r[SEL_BUS16], sel_s_r[SEL_ENCRYPT],
                                  sel_s_r[SEL_COMPRESS]);
            user_opt_r <= sel_s_r[SEL_USER_INIT];
            bus16_r <= sel_s_r[SEL_BUS16];
            link_clr_r <= 1'b0;
            status_low_r <= 1'b0;
            state_r <= DEV_LOAD;
          end
        end
        DEV_LOAD: begin
          if (done_s_r) begin
            complete_r <= 1'b1;
            state_r <= DEV_INIT_WAIT;
            cnt_r <= '0;
          end
        end
        DEV_INIT_WAIT: begin
          if (!user_opt_r) begin
            state_r <= DEV_INIT;
          end else if (cnt_r == CNT_W'(CD2CU_CYC - 1)) begin
            user_clock_enable <= 1'b1;
            cnt_r <= '0;
            state_r <= DEV_INIT;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        DEV_INIT: begin
          if (init_tick) begin
            if (cnt_r == CNT_W'(INIT_COUNT - 1)) begin
              user_mode <= 1'b1;
              state_r <= DEV_USER;
            end else begin
              cnt_r <= cnt_r + 1'b1;
            end
          end
        end
        DEV_USER: begin
          state_r <= DEV_USER;
        end
        default: begin
          state_r <= DEV_POR;
          cnt_r <= '0;
        end
      endcase
    end
  end

  assign link.status_out = 1'b0;
  assign link.status_oe = status_low_r;
  assign link.load_complete = complete_r;

  ////////////////////////////////////////////////////////////////////////////
  // Capture on the load clock

  logic link_rst;
  logic [RATIO_W-1:0] phase_r;
  logic [WORD_W-1:0] words_r;
  logic [WORD_W-1:0] words_plus;
  logic [DATA_W-1:0] csum_r;
  logic [DATA_W-1:0] data_mask;

  // Cleared from the sequencer while the load clock is stopped
  assign link_rst = sys_rst || link_clr_r;
  assign words_plus = words_r + WORD_W'(phase_r == '0);
  // Frozen width, so the link side never reads a moving strap
  assign data_mask = bus16_r ? 16'hffff : 16'h00ff;

  always_ff @(posedge link.load_clock or posedge link_rst) begin
    if (link_rst) begin
      phase_r <= '0;
      words_r <= '0;
      csum_r <= '0;
      link_done_r <= 1'b0;
    end else if (!link_done_r) begin
      if (phase_r == '0) begin
        csum_r <= csum_r ^ (link.load_data & data_mask);
        words_r <= words_plus;
      end
      if (phase_r == ratio_r - 3'h1) begin
        phase_r <= '0;
        if (words_plus == WORD_W'(IMAGE_WORDS)) begin
          link_done_r <= 1'b1;
        end
      end else begin
        phase_r <= phase_r + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Image result, stable once the done level has crossed

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      image_check <= '0;
      image_loaded <= 1'b0;
    end else if (state_r == DEV_STAT_LOW) begin
      image_loaded <= 1'b0;
    end else if (state_r == DEV_LOAD && done_s_r) begin
      image_check <= csum_r;
      image_loaded <= 1'b1;
    end
  end

endmodule

// ---- src/fpcl_host.sv ----
`timescale 1ns/1ps
module fpcl_fifo #(
  parameter int WIDTH = fpcl_pkg::DATA_W,
  parameter int DEPTH = fpcl_pkg::FIFO_DEPTH_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  // Pointers wrap naturally, so DEPTH must be a power of two
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_r, rd_r;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data = mem[rd_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wr_r <= wr_r + AW'(push);
      rd_r <= rd_r + AW'(pop);
      cnt_r <= cnt_nxt;
      in_ready <= cnt_nxt != (AW+1)'(DEPTH);
      out_valid <= cnt_nxt != '0;
    end
  end
endmodule

module fpcl_host #(
  parameter int IMAGE_WORDS = fpcl_pkg::IMAGE_WORDS_DEF,
  parameter int DIV = fpcl_pkg::HOST_DIV_DEF,
  parameter int FIFO_DEPTH = fpcl_pkg::FIFO_DEPTH_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  fpcl_link_if.host link,
  input wire logic start,
  input wire logic cfg_bus16,
  input wire logic cfg_encrypt,
  input wire logic cfg_compress,
  input wire logic [fpcl_pkg::DATA_W-1:0] img_data,
  input wire logic img_valid,
  output logic img_ready,
  output logic busy,
  output logic success,
  output logic fail
);
  import fpcl_pkg::*;

  localparam int WORD_W = $clog2(IMAGE_WORDS + 1);
  localparam int TICK_W = $clog2(2 * DIV);

  ////////////////////////////////////////////////////////////////////////////
  // Image buffer and pin synchronisers

  logic [DATA_W-1:0] f_data;
  logic f_valid, f_pop;

  fpcl_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_data(img_data),
    .in_valid(img_valid),
    .in_ready(img_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_pop)
  );

  logic stat_m_r, stat_s_r, done_m_r, done_s_r;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stat_m_r <= 1'b1;
      stat_s_r <= 1'b1;
      done_m_r <= 1'b0;
      done_s_r <= 1'b0;
    end else begin
      stat_m_r <= link.config_status_n;
      stat_s_r <= stat_m_r;
      done_m_r <= link.load_complete;
      done_s_r <= done_m_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Load sequencer

  fpcl_host_state_t state_r;
  logic [CNT_W-1:0] cnt_r;
  logic [RATIO_W-1:0] ratio_r, rep_r;
  logic [TICK_W-1:0] tick_r;
  logic [WORD_W-1:0] sent_r;
  logic have_r, req_n_r, lclk_r;
  logic [DATA_W-1:0] data_r;

  // Buffer stalls the clock low, never mid-word
  assign f_pop = state_r == HST_STREAM && !have_r && sent_r != WORD_W'(IMAGE_WORDS);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= HST_IDLE;
      cnt_r <= '0;
      ratio_r <= 3'h1;
      rep_r <= '0;
      tick_r <= '0;
      sent_r <= '0;
      have_r <= 1'b0;
      req_n_r <= 1'b1;
      lclk_r <= 1'b0;
      data_r <= '0;
      busy <= 1'b0;
      success <= 1'b0;
      fail <= 1'b0;
    end else begin
      case (state_r)
        HST_IDLE, HST_DONE: begin
          if (start) begin
            ratio_r <= fpcl_ratio(cfg_bus16, cfg_encrypt, cfg_compress);
            req_n_r <= 1'b0;
            cnt_r <= '0;
            busy <= 1'b1;
            success <= 1'b0;
            fail <= 1'b0;
            state_r <= HST_REQ;
          end
        end
        HST_REQ: begin
          if (cnt_r != CNT_W'(REQ_LOW_CYC - 1)) begin
            cnt_r <= cnt_r + 1'b1;
          end else if (!stat_s_r) begin
            req_n_r <= 1'b1;
            state_r <= HST_WAIT_REL;
          end
        end
        HST_WAIT_REL: begin
          if (stat_s_r) begin
            cnt_r <= '0;
            state_r <= HST_GAP;
          end
        end
        HST_GAP: begin
          if (cnt_r == CNT_W'(ST2CK_CYC - 1)) begin
            sent_r <= '0;
            rep_r <= '0;
            have_r <= 1'b0;
            state_r <= HST_STREAM;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        HST_STREAM: begin
          if (!stat_s_r) begin
            lclk_r <= 1'b0;
            busy <= 1'b0;
            fail <= 1'b1;
            state_r <= HST_IDLE;
          end else if (have_r) begin
            if (tick_r == TICK_W'(DIV - 1)) begin
              lclk_r <= 1'b1;
            end
            if (tick_r == TICK_W'(2 * DIV - 1)) begin
              lclk_r <= 1'b0;
              tick_r <= '0;
              if (rep_r == ratio_r - 3'h1) begin
                rep_r <= '0;
                have_r <= 1'b0;
                sent_r <= sent_r + 1'b1;
              end else begin
                rep_r <= rep_r + 3'h1;
              end
            end else begin
              tick_r <= tick_r + 1'b1;
            end
          end else if (sent_r == WORD_W'(IMAGE_WORDS)) begin
            state_r <= HST_WAIT_DONE;
          end else if (f_valid) begin
            data_r <= f_data;
            have_r <= 1'b1;
            tick_r <= '0;
          end
        end
        HST_WAIT_DONE: begin
          if (done_s_r) begin
            busy <= 1'b0;
            success <= 1'b1;
            state_r <= HST_DONE;
          end else if (!stat_s_r) begin
            busy <= 1'b0;
            fail <= 1'b1;
            state_r <= HST_IDLE;
          end
        end
        default: begin
          state_r <= HST_IDLE;
        end
      endcase
    end
  end

  assign link.config_request_n = req_n_r;
  assign link.load_clock = lclk_r;
  assign link.load_data = data_r;

endmodule

// ---- verif/fpcl_link_properties.sv ----
`timescale 1ns/1ps
module fpcl_link_properties #(
  parameter int IMAGE_WORDS = 8,
  parameter int STATUS_LOW_CYCLES = 20
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic config_request_n,
  input wire logic load_clock,
  input wire logic [fpcl_pkg::DATA_W-1:0] load_data,
  input wire logic config_status_n,
  input wire logic load_complete
);
  import fpcl_pkg::*;
  localparam int RESP_MAX = REQ_RESPONSE_MAX_NS / CLK_PERIOD_NS;
  localparam int REL_MAX = STATUS_LOW_MAX_US * 1000 / CLK_PERIOD_NS;

  int req_lo_r;
  int stat_lo_r;
  int hi_r;
  int rel_r;
  int edges_r;
  logic lclk_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Watch counters; plain ints, a run never gets near overflow
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_lo_r <= 0;
      stat_lo_r <= 0;
      hi_r <= 0;
      rel_r <= 0;
      edges_r <= 0;
      lclk_r <= 1'b0;
    end else begin
      lclk_r <= load_clock;
      req_lo_r <= config_request_n ? 0 : req_lo_r + 1;
      stat_lo_r <= config_status_n ? 0 : stat_lo_r + 1;
      hi_r <= config_status_n ? hi_r + 1 : 0;
      rel_r <= (config_status_n || !config_request_n) ? 0 : rel_r + 1;
      edges_r <= !config_status_n ? 0 : edges_r + int'(load_clock && !lclk_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  request_low_min_a:
    assert property ($rose(config_request_n) |-> req_lo_r >= REQ_LOW_CYC)
      else $error("request low pulse too short");
  request_response_a:
    assert property ($fell(config_request_n) |-> ##[1:RESP_MAX]
      (!config_status_n && !load_complete))
      else $error("no response to request in time");
  complete_hold_a:
    assert property ($fell(load_complete) |-> !config_request_n)
      else $error("load complete dropped without request");
  status_low_min_a:
    assert property ($rose(config_status_n) |-> stat_lo_r >= STATUS_LOW_CYCLES)
      else $error("status low phase too short");
  status_release_max_a:
    assert property (rel_r < REL_MAX)
      else $error("status not released after request high");
  first_edge_gap_a:
    assert property ($rose(load_clock) |-> hi_r >= ST2CK_CYC)
      else $error("load clock too soon after status high");
  data_hold_high_a:
    assert property (load_clock |-> $stable(load_data))
      else $error("load data changed while load clock high");
  complete_after_image_a:
    assert property ($rose(load_complete) |-> config_status_n && edges_r >= IMAGE_WORDS)
      else $error("load complete before whole image");

  cover property ($rose(load_complete));
  cover property ($rose(config_status_n));
  cover property ($fell(config_request_n) ##[1:RESP_MAX] !config_status_n);
endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import fpcl_pkg::*;
  localparam int WORDS = 8;
  localparam int STAT_LOW = 20;
  localparam int INIT_N = 16;
  localparam int POR_F = 10;
  localparam int POR_S = 30;
  localparam int UCLK_HALF = 4;

  logic clk, sys_rst, start, bus16, enc, comp, img_valid, img_ready;
  logic busy, success, fail, uce, user_mode, image_loaded;
  logic user_clk = 1'b0;
  logic lclk_q = 1'b0;
  logic [SCHEME_W-1:0] straps;
  logic [DATA_W-1:0] img_data, image_check, next_word;
  logic [DATA_W-1:0] words_q[$];
  int fails, tests_run;
  int rises = 0;
  int uclk_cnt = 0;

  fpcl_link_if link ();
  fpcl_device #(.IMAGE_WORDS(WORDS), .STATUS_LOW_CYCLES(STAT_LOW), .INIT_COUNT(INIT_N),
    .POR_FAST_CYCLES(POR_F), .POR_STD_CYCLES(POR_S)) i_fpcl_device (
    .clk(clk), .sys_rst(sys_rst), .link(link.dev), .scheme_select_pins(straps),
    .user_init_clock(user_clk), .user_clock_enable(uce), .user_mode(user_mode),
    .image_loaded(image_loaded), .image_check(image_check));
  fpcl_host #(.IMAGE_WORDS(WORDS), .DIV(2), .FIFO_DEPTH(32)) i_fpcl_host (
    .clk(clk), .sys_rst(sys_rst), .link(link.host), .start(start), .cfg_bus16(bus16),
    .cfg_encrypt(enc), .cfg_compress(comp), .img_data(img_data), .img_valid(img_valid),
    .img_ready(img_ready), .busy(busy), .success(success), .fail(fail));
  fpcl_link_properties #(.IMAGE_WORDS(WORDS), .STATUS_LOW_CYCLES(STAT_LOW))
    i_fpcl_link_properties (
    .clk(clk), .sys_rst(sys_rst), .config_request_n(link.config_request_n),
    .load_clock(link.load_clock), .load_data(link.load_data),
    .config_status_n(link.config_status_n), .load_complete(link.load_complete));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Slow user clock, well under a quarter of clk so the sampler sees every edge
  always @(posedge clk) begin
    uclk_cnt <= (uclk_cnt == UCLK_HALF - 1) ? 0 : uclk_cnt + 1;
    if (uclk_cnt == UCLK_HALF - 1) user_clk <= ~user_clk;
  end

  always @(posedge clk) begin
    lclk_q <= link.load_clock;
    if (link.load_clock === 1'b1 && lclk_q === 1'b0) rises <= rises + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  function automatic int exp_ratio(input logic b16, input logic e, input logic c);
    if (!b16) return c ? 2 : 1;
    if (c) return 4;
    return e ? 2 : 1;
  endfunction

  task automatic do_reset(input logic fast, input int por);
    int n;
    n = 0;
    @(posedge clk);
    straps <= fast ? 5'h08 : 5'h00;
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    while (link.config_status_n !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    check(n >= por + STAT_LOW && n <= por + STAT_LOW + 8, 1'b1, "power-on delay");
    $display("Test power-on fast=%0b done", fast);
  endtask

  // Pushes are spaced out so the host meets an empty buffer mid-stream
  task automatic run_load(input logic [2:0] cfg, input logic usr, input int pushes);
    int n, base, t_lc, t_ue, t_um, r, pushed, dl, du;
    logic armed;
    logic [DATA_W-1:0] x;
    r = exp_ratio(cfg[0], cfg[1], cfg[2]);
    n = 0;
    pushed = 0;
    t_lc = -1;
    t_ue = -1;
    t_um = -1;
    armed = 1'b0;
    x = 16'h0000;
    @(posedge clk);
    straps <= {usr, 1'b0, cfg[2], cfg[1], cfg[0]};
    bus16 <= cfg[0];
    enc <= cfg[1];
    comp <= cfg[2];
    @(posedge clk);
    start <= 1'b1;
    base = rises;
    @(posedge clk);
    start <= 1'b0;
    while (!(t_um >= 0 && busy === 1'b0) && n < 4000) begin
      @(posedge clk);
      n++;
      if (img_valid === 1'b1 && img_ready === 1'b1) begin
        words_q.push_back(img_data);
        img_valid <= 1'b0;
      end else if (img_valid !== 1'b1 && pushed < pushes && n % 40 == 0) begin
        img_data <= next_word;
        img_valid <= 1'b1;
        next_word = next_word * 16'h0005 + 16'h3c71;
        pushed++;
      end
      armed = armed || link.load_complete === 1'b0;
      if (armed && t_lc < 0 && link.load_complete === 1'b1) t_lc = n;
      if (t_lc >= 0 && t_ue < 0 && uce === 1'b1) t_ue = n;
      if (t_lc >= 0 && t_um < 0 && user_mode === 1'b1) t_um = n;
    end
    repeat (WORDS) x = x ^ words_q.pop_front();
    if (!cfg[0]) x = x & 16'h00ff;
    dl = t_ue - t_lc;
    du = t_um - t_lc;
    check(success, 1'b1, "load success");
    check(fail, 1'b0, "load fail flag");
    check(image_loaded, 1'b1, "image loaded");
    check(image_check, x, "image check");
    check(rises - base, WORDS * r, "load clock edges");
    if (usr) begin
      check(dl >= CD2CU_CYC && dl <= CD2CU_CYC + 4, 1'b1, "user clock enable");
      check(du >= CD2CU_CYC + (INIT_N - 1) * 2 * UCLK_HALF
        && du <= CD2CU_CYC + (INIT_N + 3) * 2 * UCLK_HALF, 1'b1, "user init");
    end else begin
      check(uce, 1'b0, "user clock left off");
      check(du >= INIT_N && du <= INIT_N + 6, 1'b1, "internal init");
    end
    $display("Test load cfg=%0h user=%0b done", cfg, usr);
  endtask

  // Fill the buffer while the host is idle until it refuses
  task automatic fill_fifo();
    int n;
    n = 0;
    img_data <= next_word;
    img_valid <= 1'b1;
    repeat (40) begin
      @(posedge clk);
      if (img_ready === 1'b1) begin
        words_q.push_back(next_word);
        next_word = next_word * 16'h0005 + 16'h3c71;
        img_data <= next_word;
        n++;
      end
    end
    img_valid <= 1'b0;
    check(n, 32, "buffer depth");
    $display("Test buffer fill done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    straps = 5'h00;
    start = 1'b0;
    bus16 = 1'b0;
    enc = 1'b0;
    comp = 1'b0;
    img_valid = 1'b0;
    img_data = 16'h0000;
    next_word = 16'ha5c3;
    fails = 0;
    tests_run = 0;
    do_reset(1'b0, POR_S);
    do_reset(1'b1, POR_F);
    for (int i = 0; i < 4; i++) run_load(3'(i), 1'b0, WORDS);
    fill_fifo();
    for (int i = 4; i < 8; i++) run_load(3'(i), i == 7, 0);
    check(img_ready, 1'b1, "buffer drained");
    print_verdict();
  end

  // Whole run is under ten thousand cycles; allow about twice that
  initial begin
    #500000;
    fails++;
    print_verdict();
  end
endmodule
